/* design/dmsp_port.sv */
// Purpose: Two-wire / SPI-style register port of a bias controller
// Assumes: Link pins are asynchronous; sys_clk oversamples them >= 4x
// Notes:   Register file sits outside; rd_data is valid the cycle after rd_stb
`timescale 1ns/10ps
`default_nettype none
`include "dmsp_regs.svh"

//////////////////////////////////////////////////////////////////////////////
module dmsp_port
    import dmsp_pkg::*;
#(
    parameter int WORD_W = 16
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              clk_en,
    input  wire logic              spi_mode_sel,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    input  wire logic              device_select_low,
    output logic                   spi_dout,
    input  wire logic              address_select_bit2,
    input  wire logic              address_select_bit1,
    input  wire logic              address_select_bit0,
    output logic                   hs_mode,
    output logic                   wr_stb,
    output logic                   rd_stb,
    output logic [6:0]             reg_index,
    output logic [WORD_W-1:0]      wr_data,
    input  wire logic [WORD_W-1:0] rd_data
);

    generate
        if (WORD_W != 16) begin : g_bad_width
            $error("dmsp_port serves a 16-bit data word only");
        end
    endgenerate

    // Scaled in two steps so the product stays inside a 32-bit int
    localparam int SPI_SAMPLES = `DMSP_LINK_NS * (`DMSP_SYS_HZ / 1000000) / 1000;

    generate
        if (SPI_SAMPLES < 4) begin : g_slow_clock
            $error("sys_clk too slow to oversample the serial clock");
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    logic [6:0] pin_m_r;
    logic [6:0] pin_s_r;
    logic       scl_d_r;
    logic       sda_d_r;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_m_r <= 7'h7f;
            pin_s_r <= 7'h7f;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (clk_en) begin
            pin_m_r <= {scl_in, sda_in, device_select_low, spi_mode_sel,
                        address_select_bit2, address_select_bit1, address_select_bit0};
            pin_s_r <= pin_m_r;
            scl_d_r <= pin_s_r[6];
            sda_d_r <= pin_s_r[5];
        end
    end

    logic scl_s, sda_s, csn_s, spi_s;
    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_s = pin_s_r[6];
    assign sda_s = pin_s_r[5];
    assign csn_s = pin_s_r[4];
    assign spi_s = pin_s_r[3];
    assign scl_rise  = clk_en & scl_s & ~scl_d_r;
    assign scl_fall  = clk_en & ~scl_s & scl_d_r;
    assign start_det = clk_en & ~spi_s & scl_s & scl_d_r & ~sda_s & sda_d_r;
    assign stop_det  = clk_en & ~spi_s & scl_s & scl_d_r & sda_s & ~sda_d_r;

    //////////////////////////////////////////////////////////////////////////
    // Two-wire framing
    dmsp_i2c_st_t i_st_r;
    dmsp_i2c_st_t i_st_nxt;
    logic [3:0]   i_cnt_r;
    logic [7:0]   i_sh_r;
    logic [7:0]   rx_byte;
    logic         rx_last, ack_rise;
    logic         ack_nxt, rd_req, addr_hit, hs_code;
    logic [7:0]   last_cmd_r;
    logic         rd_first_r;

    assign rx_byte  = {i_sh_r[6:0], sda_s};
    assign rx_last  = scl_rise & ~spi_s & (i_st_r != DMSP_IDLE) & (i_cnt_r == `DMSP_BYTE_LAST);
    assign ack_rise = scl_rise & ~spi_s & (i_st_r != DMSP_IDLE) & (i_cnt_r == `DMSP_ACK_SLOT);
    assign addr_hit = rx_byte[7:1] == {`DMSP_ADDR_FIXED, pin_s_r[2:0]};
    assign hs_code  = rx_byte[7:3] == `DMSP_HS_CODE;

    always_comb begin
        i_st_nxt = i_st_r;
        ack_nxt  = 1'b0;
        rd_req   = 1'b0;
        unique case (i_st_r)
            DMSP_ADDR: begin
                if (hs_code) begin
                    i_st_nxt = DMSP_SKIP;
                end else if (addr_hit) begin
                    ack_nxt  = 1'b1;
                    rd_req   = rx_byte[0];
                    i_st_nxt = rx_byte[0] ? DMSP_RHI : DMSP_CMD;
                end else begin
                    i_st_nxt = DMSP_SKIP;
                end
            end
            DMSP_CMD: begin
                ack_nxt  = 1'b1;
                i_st_nxt = rx_byte[`DMSP_CMD_RD_BIT] ? DMSP_SKIP : DMSP_WHI;
            end
            DMSP_WHI: begin
                ack_nxt  = 1'b1;
                i_st_nxt = DMSP_WLO;
            end
            DMSP_WLO: begin
                ack_nxt  = (last_cmd_r != `DMSP_CMD_SWCLR);
                i_st_nxt = DMSP_WHI;
            end
            DMSP_IDLE, DMSP_RHI, DMSP_RLO, DMSP_SKIP: begin
                i_st_nxt = i_st_r;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            i_st_r  <= DMSP_IDLE;
            i_cnt_r <= 4'h0;
            i_sh_r  <= 8'h00;
            rd_first_r <= 1'b0;
        end else if (start_det) begin
            i_st_r  <= DMSP_ADDR;
            i_cnt_r <= 4'h0;
            rd_first_r <= 1'b0;
        end else if (stop_det) begin
            i_st_r  <= DMSP_IDLE;
            i_cnt_r <= 4'h0;
            rd_first_r <= 1'b0;
        end else if (scl_rise && !spi_s && i_st_r != DMSP_IDLE) begin
            i_cnt_r <= (i_cnt_r == `DMSP_ACK_SLOT) ? 4'h0 : i_cnt_r + 4'h1;
            if (i_cnt_r != `DMSP_ACK_SLOT) begin
                i_sh_r <= rx_byte;
            end
            if (rx_last) begin
                i_st_r     <= i_st_nxt;
                rd_first_r <= rd_req;
            end else if (ack_rise && rd_first_r) begin
                // Own ACK of the read address, not a master ACK
                rd_first_r <= 1'b0;
            end else if (ack_rise && i_st_r == DMSP_RHI) begin
                i_st_r <= sda_s ? DMSP_SKIP : DMSP_RLO;
            end else if (ack_rise && i_st_r == DMSP_RLO) begin
                i_st_r <= sda_s ? DMSP_SKIP : DMSP_RHI;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Two-wire acknowledge, command and strobes
    logic       ack_r;
    logic [7:0] wr_hi_r;
    logic       i_wr_r, i_rd_r, poll_rd;
    logic [15:0] i_wdata_r;

    assign poll_rd = ack_rise & (i_st_r == DMSP_RLO) & ~sda_s;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_r      <= 1'b0;
            last_cmd_r <= 8'h00;
            wr_hi_r    <= 8'h00;
            i_wr_r     <= 1'b0;
            i_rd_r     <= 1'b0;
            i_wdata_r  <= 16'h0000;
        end else if (clk_en) begin
            i_wr_r <= 1'b0;
            i_rd_r <= 1'b0;
            if (start_det || stop_det) begin
                ack_r <= 1'b0;
            end else if (rx_last) begin
                ack_r  <= ack_nxt;
                i_rd_r <= rd_req;
                if (i_st_r == DMSP_CMD) begin
                    last_cmd_r <= rx_byte;
                end
                if (i_st_r == DMSP_WHI) begin
                    wr_hi_r <= rx_byte;
                end
                if (i_st_r == DMSP_WLO) begin
                    i_wr_r    <= 1'b1;
                    i_wdata_r <= {wr_hi_r, rx_byte};
                end
            end else if (poll_rd) begin
                i_rd_r <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Two-wire data drive, changed only while the clock is low
    logic        rd_cap_r;
    logic [15:0] rd_word_r;
    logic [7:0]  tx_sh_r;
    logic        sda_oe_r;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_cap_r  <= 1'b0;
            rd_word_r <= 16'h0000;
            tx_sh_r   <= 8'h00;
            sda_oe_r  <= 1'b0;
        end else if (clk_en) begin
            rd_cap_r <= rd_stb;
            if (rd_cap_r) begin
                rd_word_r <= rd_data;
                tx_sh_r   <= rd_data[15:8];
            end else if (ack_rise && i_st_r == DMSP_RHI && !rd_first_r) begin
                tx_sh_r   <= rd_word_r[7:0];
            end
            if (start_det || stop_det || spi_s) begin
                sda_oe_r <= 1'b0;
            end else if (scl_fall) begin
                if (i_cnt_r == `DMSP_ACK_SLOT) begin
                    sda_oe_r <= ack_r;
                end else if (i_st_r == DMSP_RHI || i_st_r == DMSP_RLO) begin
                    sda_oe_r <= ~tx_sh_r[7];
                    tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
                end else begin
                    sda_oe_r <= 1'b0;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Speed mode
    logic hs_r, hs_pend_r;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hs_r      <= 1'b0;
            hs_pend_r <= 1'b0;
        end else if (clk_en) begin
            if (stop_det || spi_s) begin
                hs_r      <= 1'b0;
                hs_pend_r <= 1'b0;
            end else if (rx_last && i_st_r == DMSP_ADDR && hs_code) begin
                hs_pend_r <= 1'b1;
            end else if (hs_pend_r && scl_rise && i_cnt_r != `DMSP_ACK_SLOT) begin
                hs_r      <= 1'b1;
                hs_pend_r <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // SPI framing; rate is bounded by the oversampling of sys_clk
    logic [4:0]  s_cnt_r;
    logic [22:0] s_sh_r;
    logic [7:0]  s_cmd_r;
    logic        s_wr_r, s_rd_r, s_rd_cap_r, s_rd_op;
    logic [15:0] s_wdata_r;
    logic [15:0] s_tx_r;
    logic        s_dout_r;
    logic        s_rise;

    assign s_rise  = scl_rise & spi_s & ~csn_s & (s_cnt_r != `DMSP_SPI_BITS);
    assign s_rd_op = s_cmd_r[`DMSP_CMD_RD_BIT];

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_cnt_r   <= 5'h00;
            s_sh_r    <= 23'h000000;
            s_cmd_r   <= 8'h00;
            s_wr_r    <= 1'b0;
            s_rd_r    <= 1'b0;
            s_wdata_r <= 16'h0000;
        end else if (clk_en) begin
            s_wr_r <= 1'b0;
            s_rd_r <= 1'b0;
            if (csn_s || !spi_s) begin
                s_cnt_r <= 5'h00;
            end else if (s_rise) begin
                s_cnt_r <= s_cnt_r + 5'h01;
                s_sh_r  <= {s_sh_r[21:0], sda_s};
                if (s_cnt_r == `DMSP_SPI_CMD_END) begin
                    s_cmd_r <= {s_sh_r[6:0], sda_s};
                    s_rd_r  <= sda_s;
                end
                if (s_cnt_r == `DMSP_SPI_LAST && !s_rd_op) begin
                    s_wr_r    <= 1'b1;
                    s_wdata_r <= {s_sh_r[14:0], sda_s};
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_rd_cap_r <= 1'b0;
            s_tx_r     <= 16'h0000;
            s_dout_r   <= 1'b0;
        end else if (clk_en) begin
            s_rd_cap_r <= s_rd_r;
            if (s_rd_cap_r) begin
                s_tx_r <= rd_data;
            end else if (scl_fall && spi_s && !csn_s && s_rd_op
                         && s_cnt_r >= `DMSP_SPI_DAT_BEG && s_cnt_r <= `DMSP_SPI_LAST) begin
                s_dout_r <= s_tx_r[15];
                s_tx_r   <= {s_tx_r[14:0], 1'b0};
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs
    assign sda_out   = 1'b0;
    assign sda_oe    = sda_oe_r;
    assign spi_dout  = s_dout_r;
    assign hs_mode   = hs_r;
    assign wr_stb    = spi_s ? s_wr_r : i_wr_r;
    assign rd_stb    = spi_s ? s_rd_r : i_rd_r;
    assign reg_index = spi_s ? s_cmd_r[7:1] : last_cmd_r[7:1];
    assign wr_data   = spi_s ? s_wdata_r : i_wdata_r;

    //////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_stop_release;
        stop_det |=> !sda_oe && !hs_mode;
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("bus held or HS after STOP");

    property p_start_frame;
        start_det |=> i_st_r == DMSP_ADDR && i_cnt_r == 4'h0;
    endproperty
    a_start_frame: assert property (p_start_frame) else $error("START did not reframe");

    property p_hs_pend;
        rx_last && i_st_r == DMSP_ADDR && hs_code && !hs_mode |=> !ack_r && !hs_mode;
    endproperty
    a_hs_pend: assert property (p_hs_pend) else $error("HS code acknowledged or switched early");

    property p_hs_enter;
        hs_pend_r && !hs_mode && scl_rise && !stop_det && !spi_s
            |=> hs_mode == ($past(i_cnt_r) != `DMSP_ACK_SLOT);
    endproperty
    a_hs_enter: assert property (p_hs_enter) else $error("HS mode not entered on tenth rise");

    property p_rstart_keeps;
        start_det && hs_mode |=> hs_mode;
    endproperty
    a_rstart_keeps: assert property (p_rstart_keeps) else $error("repeated START changed speed");

    property p_swclr_nack;
        rx_last && i_st_r == DMSP_WLO && last_cmd_r == `DMSP_CMD_SWCLR && !stop_det |=> !ack_r;
    endproperty
    a_swclr_nack: assert property (p_swclr_nack) else $error("software clear byte acknowledged");

    property p_addr_ack;
        rx_last && i_st_r == DMSP_ADDR && addr_hit && !hs_code |=> ack_r;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

    property p_ack_drive;
        scl_fall && i_cnt_r == `DMSP_ACK_SLOT && ack_r && !spi_s && !start_det && !stop_det |=> sda_oe;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("ACK not driven");

    property p_spi_abort;
        spi_s && csn_s && clk_en |=> s_cnt_r == 5'h00 && !wr_stb;
    endproperty
    a_spi_abort: assert property (p_spi_abort) else $error("partial SPI frame kept");

    property p_spi_rd_req;
        s_rise && s_cnt_r == `DMSP_SPI_CMD_END && sda_s |=> rd_stb ##2 s_tx_r == $past(rd_data);
    endproperty
    a_spi_rd_req: assert property (p_spi_rd_req) else $error("SPI read not requested");

    property p_spi_dout;
        scl_fall && spi_s && !csn_s && s_rd_op && !s_rd_cap_r && s_cnt_r == `DMSP_SPI_DAT_BEG
            |=> spi_dout == $past(s_tx_r[15]);
    endproperty
    a_spi_dout: assert property (p_spi_dout) else $error("SPI MSB not shifted out");

endmodule
`default_nettype wire

/* design/dmsp_regs.svh */
// Purpose: Constants of the dual mode serial register port
// Assumes: Included by the port module and the testbench
// Notes:   Counts are in link bits, not clock cycles
`ifndef DMSP_REGS_SVH
`define DMSP_REGS_SVH

`define DMSP_ADDR_FIXED  4'h4
`define DMSP_HS_CODE     5'h01
`define DMSP_CMD_RD_BIT  0
`define DMSP_CMD_SWCLR   8'h7e
`define DMSP_BYTE_LAST   4'h7
`define DMSP_ACK_SLOT    4'h8
`define DMSP_SPI_CMD_END 5'h07
`define DMSP_SPI_DAT_BEG 5'h08
`define DMSP_SPI_LAST    5'h17
`define DMSP_SPI_BITS    5'h18
`define DMSP_SYS_HZ      25000000
`define DMSP_LINK_NS     320

`endif

/* design/dmsp_pkg.sv */
// Purpose: Types shared by the dual mode serial register port
// Assumes: Nothing beyond the constant header
// Notes:   State codes are left to the tools
package dmsp_pkg;

    typedef enum logic [2:0] {
        DMSP_IDLE,
        DMSP_ADDR,
        DMSP_CMD,
        DMSP_WHI,
        DMSP_WLO,
        DMSP_RHI,
        DMSP_RLO,
        DMSP_SKIP
    } dmsp_i2c_st_t;

endpackage

/* test/dmsp_master.sv */
// Purpose: Bus master model driving the serial register port
// Assumes: Link bit takes eight sys_clk cycles; changes at falling edges
// Notes:   Two-wire data is open drain with a pull-up
`timescale 1ns/10ps
`default_nettype none
module dmsp_master (
    input  wire logic sys_clk,
    input  wire logic spi_mode,
    input  wire logic sda_oe,
    input  wire logic sda_out,
    input  wire logic spi_dout,
    output logic      scl,
    output logic      sda,
    output logic      sel_n
);
    logic mpull;
    logic mosi;

    // Wired level; idle high when nobody pulls
    assign sda = spi_mode ? mosi : (!mpull & (sda_oe ? sda_out : 1'b1));

    initial begin
        mpull = 1'b0;
        mosi  = 1'b1;
        scl   = 1'b1;
        sel_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Data changes only while the clock is low; sampled late in high phase
    task automatic bit_x(input logic tx, output logic rx);
        scl = 1'b0;
        cyc(1);
        mpull = !tx;
        mosi  = tx;
        cyc(3);
        scl = 1'b1;
        cyc(3);
        rx = spi_mode ? spi_dout : sda;
        cyc(1);
    endtask

    task automatic setup_hi(input logic pull);
        scl = 1'b0;
        cyc(1);
        mpull = pull;
        cyc(3);
        scl = 1'b1;
        cyc(4);
    endtask

    task automatic start(input logic rep);
        if (rep) begin
            setup_hi(1'b0);
        end
        mpull = 1'b1;
        cyc(4);
    endtask

    task automatic stop();
        setup_hi(1'b1);
        mpull = 1'b0;
        cyc(8);
    endtask

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], r);
        end
        bit_x(1'b1, r);
        ack = !r;
    endtask

    // Master acknowledge keeps the read going, not-acknowledge ends it
    task automatic rd_byte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            b[i] = r;
        end
        bit_x(!ack, r);
    endtask

    task automatic spi_frame(input logic [23:0] w, input logic cpol, input int n,
                             output logic [15:0] q);
        logic r;
        q = 16'h0;
        scl = cpol;
        cyc(4);
        sel_n = 1'b0;
        cyc(4);
        for (int i = 0; i < n; i++) begin
            bit_x(w[23 - i], r);
            if (i >= 8) begin
                q[23 - i] = r;
            end
        end
        scl = cpol;
        cyc(4);
        sel_n = 1'b1;
        mosi = !mosi;
        cyc(8);
    endtask
endmodule
`default_nettype wire

/* test/tb_dmsp_port.sv */
// Purpose: Self-checking bench of the dual mode serial register port
// Assumes: Link bit period 320 ns; inputs change at falling edges
// Notes:   Strobes are matched against a queue of expected requests
`timescale 1ns/10ps
`default_nettype none
`include "dmsp_regs.svh"
module tb_dmsp_port;
    logic        sys_clk;
    logic        nrst;
    logic        spi_mode_sel;
    logic [2:0]  asel;
    logic [15:0] rd_data;
    logic [15:0] salt;
    logic [6:0]  last;
    logic [23:0] exp_q[$];
    integer      seed = 32'h6ea93b41;
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    wire         scl;
    wire         sda;
    wire         sel_n;
    wire         sda_oe;
    wire         sda_out;
    wire         spi_dout;
    wire         hs_mode;
    wire         wr_stb;
    wire         rd_stb;
    wire [6:0]   reg_index;
    wire [15:0]  wr_data;

    dmsp_port u_dmsp_port (
        .sys_clk             (sys_clk),
        .nrst                (nrst),
        .clk_en              (1'b1),
        .spi_mode_sel        (spi_mode_sel),
        .scl_in              (scl),
        .sda_in              (sda),
        .sda_out             (sda_out),
        .sda_oe              (sda_oe),
        .device_select_low   (sel_n),
        .spi_dout            (spi_dout),
        .address_select_bit2 (asel[2]),
        .address_select_bit1 (asel[1]),
        .address_select_bit0 (asel[0]),
        .hs_mode             (hs_mode),
        .wr_stb              (wr_stb),
        .rd_stb              (rd_stb),
        .reg_index           (reg_index),
        .wr_data             (wr_data),
        .rd_data             (rd_data)
    );

    dmsp_master u_dmsp_master (
        .sys_clk  (sys_clk),
        .spi_mode (spi_mode_sel),
        .sda_oe   (sda_oe),
        .sda_out  (sda_out),
        .spi_dout (spi_dout),
        .scl      (scl),
        .sda      (sda),
        .sel_n    (sel_n)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rdv(input logic [6:0] i);
        return {i, 2'b10, i} ^ salt;
    endfunction

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Register file stand-in answers from the requested index
    always @(negedge sys_clk) rd_data <= rdv(reg_index);

    // Outputs looked at mid-cycle, away from the launching edge
    always @(negedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            report_and_stop();
        end
        if (wr_stb === 1'b1 || rd_stb === 1'b1) begin
            check({rd_stb, reg_index, rd_stb ? 16'h0 : wr_data}, exp_q.size() ? exp_q.pop_front() : 'x);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tw_hdr(input logic rep, input logic rw, input logic [7:0] c);
        logic a;
        if (rw) begin
            exp_q.push_back({1'b1, last, 16'h0});
        end
        u_dmsp_master.start(rep);
        u_dmsp_master.wr_byte({`DMSP_ADDR_FIXED, asel, rw}, a);
        check(24'(a), 24'h1);
        if (!rw) begin
            u_dmsp_master.wr_byte(c, a);
            check(24'(a), 24'h1);
            last = c[7:1];
        end
    endtask

    task automatic tw_word(input logic [7:0] c, input logic [15:0] d);
        logic a;
        exp_q.push_back({1'b0, c[7:1], d});
        u_dmsp_master.wr_byte(d[15:8], a);
        check(24'(a), 24'h1);
        u_dmsp_master.wr_byte(d[7:0], a);
        check(24'(a), 24'(c != `DMSP_CMD_SWCLR));
    endtask

    task automatic tw_read(input int n);
        logic [7:0] hi;
        logic [7:0] lo;
        for (int k = 0; k < n; k++) begin
            u_dmsp_master.rd_byte(1'b1, hi);
            if (k < n - 1) begin
                exp_q.push_back({1'b1, last, 16'h0});
            end
            u_dmsp_master.rd_byte(k < n - 1, lo);
            check({8'h0, hi, lo}, {8'h0, rdv(last)});
        end
    endtask

    initial begin
        logic [7:0]  c;
        logic [15:0] d;
        logic [15:0] q;
        logic        a;
        nrst = 1'b0;
        spi_mode_sel = 1'b0;
        asel = 3'($random(seed));
        salt = 16'($random(seed));
        last = 7'h0;
        repeat (5) @(negedge sys_clk);
        check({21'h0, sda_oe, hs_mode, wr_stb | rd_stb}, 24'h0);
        nrst = 1'b1;
        repeat (4) @(negedge sys_clk);
        c = {1'b1, 6'($random(seed)), 1'b0};
        d = 16'($random(seed));
        tw_hdr(1'b0, 1'b0, c);
        tw_word(c, d);
        tw_word(c, ~d);
        u_dmsp_master.stop();
        check(24'(sda_oe), 24'h0);
        tw_hdr(1'b0, 1'b1, c);
        tw_read(2);
        u_dmsp_master.stop();
        // Foreign address is ignored
        u_dmsp_master.start(1'b0);
        u_dmsp_master.wr_byte({`DMSP_ADDR_FIXED, ~asel, 1'b0}, a);
        check(24'(a), 24'h0);
        u_dmsp_master.stop();
        tw_hdr(1'b0, 1'b0, `DMSP_CMD_SWCLR);
        tw_word(`DMSP_CMD_SWCLR, d);
        u_dmsp_master.stop();
        tw_hdr(1'b0, 1'b0, c | 8'h01);
        tw_hdr(1'b1, 1'b1, c);
        tw_read(1);
        u_dmsp_master.stop();
        // Speed switch, work under repeated starts, back on stop
        u_dmsp_master.start(1'b0);
        u_dmsp_master.wr_byte({`DMSP_HS_CODE, 3'($random(seed))}, a);
        check(24'(a), 24'h0);
        tw_hdr(1'b1, 1'b0, c);
        check(24'(hs_mode), 24'h1);
        tw_word(c, d);
        tw_hdr(1'b1, 1'b1, c);
        tw_read(1);
        check(24'(hs_mode), 24'h1);
        u_dmsp_master.stop();
        check(24'(hs_mode), 24'h0);
        spi_mode_sel = 1'b1;
        repeat (4) @(negedge sys_clk);
        for (int p = 0; p < 2; p++) begin
            c = {1'b1, 6'($random(seed)), 1'b0};
            d = 16'($random(seed));
            exp_q.push_back({1'b0, c[7:1], d});
            u_dmsp_master.spi_frame({c, d}, p[0], 24, q);
            c[0] = 1'b1;
            exp_q.push_back({1'b1, c[7:1], 16'h0});
            u_dmsp_master.spi_frame({c, d}, p[0], 24, q);
            check({8'h0, q}, {8'h0, rdv(c[7:1])});
            c[0] = 1'b0;
            u_dmsp_master.spi_frame({c, d}, p[0], p ? 23 : 9, q);
        end
        repeat (8) @(negedge sys_clk);
        check(24'(exp_q.size()), 24'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
